// [spb_host.sv]
// Register bus master standing in for configuration software
`timescale 1ns/1ps
module spb_host (
	// Clock
	input wire logic clock,
	// Register port
	output logic [11:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd
);
	initial begin
		addr = 12'h000;
		wdata = 32'h0000_0000;
		wr = 1'b0;
		rd = 1'b0;
	end
	// One access per cycle, write or read
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		wr <= w;
		rd <= ~w;
		addr <= a;
		wdata <= d;
		@(posedge clock);
	endtask : acc
	// Idle cycle, bus lines scrambled
	task automatic idle();
		wr <= 1'b0;
		rd <= 1'b0;
		addr <= ~addr;
		wdata <= ~wdata;
		@(posedge clock);
	endtask : idle
endmodule : spb_host

// [spb_pkg.sv]
// Package: offsets, field positions and reset values for the power budget and status bank
package spb_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_PB_SELECT = 12'h284;
	localparam logic [11:0] OFF_PB_READBACK = 12'h288;
	localparam logic [11:0] OFF_PB_CAP = 12'h28c;
	localparam logic [11:0] OFF_PB_WORDS = 12'h300;
	localparam logic [11:0] OFF_STATE_REPORT = 12'h328;
	localparam logic [11:0] OFF_SYS_CONTROL = 12'h32c;
	localparam int NUM_WORDS = 10;
	localparam logic [7:0] LAST_WORD_SEL = 8'h09;
	localparam int SA_BIT = 0;
	localparam int MODE_LSB = 0;
	localparam int DS_CLK_BIT = 5;
	localparam int US_CLK_BIT = 6;
	localparam int HOLD_BIT = 9;
	localparam int LOCK_LSB = 20;
	localparam int MARKER_LSB = 28;
	localparam int UNLOCK_BIT = 3;
	localparam int DV_UNLOCK_BIT = 4;
	localparam logic [2:0] LOCK_RESET = 3'h0;
	localparam logic [3:0] MARKER_RESET = 4'h0;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : spb_pkg

// [spb_regs.sv]
// Power budget capability and switch status register bank
`timescale 1ns/1ps
// Behaviour
// - System-allocated flag at capability bit zero
// - Ten sticky 32-bit budget data words
// - Budget word writes only when unlocked
// - Mode pins reported in bits 2:0
// - Downstream clock pin captured, bit 5
// - Upstream clock pin captured, bit 6
// - Reset-hold pin captured, bit 9
// - Lock state field, reset zero
// - Marker survives hot reset
// - Marker writable when globally unlocked
// - Lockable fields writable only when unlocked
// - One unlock bit for all words
// - Selected word readback, zero above nine
module spb_regs (
	// Clock and resets
	input wire logic clock,
	input wire logic rst,
	input wire logic hot_rst,
	// Register port
	input wire logic [11:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Device pins and state
	input wire logic [2:0] operating_mode_field,
	input wire logic downstream_common_clock_pin,
	input wire logic upstream_common_clock_pin,
	input wire logic reset_hold_pin,
	input wire logic [2:0] lock_state_in,
	// Status towards the switch
	output logic system_allocated_flag,
	output logic reset_hold_latched
);
	////////////////////////////////////////////////////////////////
	logic [31:0] budget_data_word [spb_pkg::NUM_WORDS];
	logic [7:0] budget_word_selector_reg;
	logic sa_reg;
	logic [2:0] mode_reg;
	logic ds_clk_reg;
	logic us_clk_reg;
	logic hold_reg;
	logic [2:0] lock_state_reg;
	logic [3:0] marker_reg;
	logic global_write_unlock_reg;
	logic budget_data_unlock_reg;
	logic [31:0] rdata_next;
	logic [31:0] readback;
	logic [31:0] status_word;
	logic [3:0] word_idx;
	logic [11:0] word_off;
	logic in_words;

	assign word_off = addr - spb_pkg::OFF_PB_WORDS;
	assign word_idx = word_off[5:2];
	assign in_words = (addr >= spb_pkg::OFF_PB_WORDS) && (word_off[1:0] == 2'h0)
		&& (word_off[11:2] < 10'(spb_pkg::NUM_WORDS));

	////////////////////////////////////////////////////////////////
	// Budget data words, no reset value
	genvar gi;
	generate
		for (gi = 0; gi < spb_pkg::NUM_WORDS; gi++) begin : g_word
			always_ff @(posedge clock) begin
				if (wr && in_words && word_idx == 4'(gi) && budget_data_unlock_reg) begin
					budget_data_word[gi] <= wdata;
				end
			end
		end
	endgenerate

	// Global unlock, set through reset for initialisation
	always_ff @(posedge clock) begin
		if (rst || hot_rst) begin
			global_write_unlock_reg <= 1'b1;
		end else if (wr && addr == spb_pkg::OFF_SYS_CONTROL) begin
			global_write_unlock_reg <= wdata[spb_pkg::UNLOCK_BIT];
		end
	end

	// Budget data unlock, itself lockable and sticky
	always_ff @(posedge clock) begin
		if (rst) begin
			budget_data_unlock_reg <= 1'b0;
		end else if (wr && addr == spb_pkg::OFF_SYS_CONTROL && global_write_unlock_reg) begin
			budget_data_unlock_reg <= wdata[spb_pkg::DV_UNLOCK_BIT];
		end
	end

	// System allocated flag, sticky, lockable
	always_ff @(posedge clock) begin
		if (rst) begin
			sa_reg <= 1'b0;
		end else if (wr && addr == spb_pkg::OFF_PB_CAP && global_write_unlock_reg) begin
			sa_reg <= wdata[spb_pkg::SA_BIT];
		end
	end

	// Word selector
	always_ff @(posedge clock) begin
		if (rst || hot_rst) begin
			budget_word_selector_reg <= 8'h00;
		end else if (wr && addr == spb_pkg::OFF_PB_SELECT) begin
			budget_word_selector_reg <= wdata[7:0];
		end
	end

	// Pin capture during fundamental reset
	always_ff @(posedge clock) begin
		if (rst) begin
			mode_reg <= operating_mode_field;
			ds_clk_reg <= downstream_common_clock_pin;
			us_clk_reg <= upstream_common_clock_pin;
			hold_reg <= reset_hold_pin;
		end
	end

	// Lock state
	always_ff @(posedge clock) begin
		if (rst || hot_rst) begin
			lock_state_reg <= spb_pkg::LOCK_RESET;
		end else begin
			lock_state_reg <= lock_state_in;
		end
	end

	// Marker, cleared only by fundamental reset
	always_ff @(posedge clock) begin
		if (rst) begin
			marker_reg <= spb_pkg::MARKER_RESET;
		end else if (wr && addr == spb_pkg::OFF_STATE_REPORT && global_write_unlock_reg) begin
			marker_reg <= wdata[spb_pkg::MARKER_LSB +: 4];
		end
	end

	////////////////////////////////////////////////////////////////
	// Read path
	always_comb begin
		if (budget_word_selector_reg > spb_pkg::LAST_WORD_SEL) begin
			readback = spb_pkg::ZERO_WORD;
		end else begin
			readback = budget_data_word[budget_word_selector_reg[3:0]];
		end
	end

	always_comb begin
		status_word = spb_pkg::ZERO_WORD;
		status_word[spb_pkg::MODE_LSB +: 3] = mode_reg;
		status_word[spb_pkg::DS_CLK_BIT] = ds_clk_reg;
		status_word[spb_pkg::US_CLK_BIT] = us_clk_reg;
		status_word[spb_pkg::HOLD_BIT] = hold_reg;
		status_word[spb_pkg::LOCK_LSB +: 3] = lock_state_reg;
		status_word[spb_pkg::MARKER_LSB +: 4] = marker_reg;
	end

	always_comb begin
		rdata_next = spb_pkg::ZERO_WORD;
		if (in_words) begin
			rdata_next = budget_data_word[word_idx];
		end else begin
			case (addr)
				spb_pkg::OFF_PB_SELECT: rdata_next = {24'h000000, budget_word_selector_reg};
				spb_pkg::OFF_PB_READBACK: rdata_next = readback;
				spb_pkg::OFF_PB_CAP: rdata_next = {31'h00000000, sa_reg};
				spb_pkg::OFF_STATE_REPORT: rdata_next = status_word;
				spb_pkg::OFF_SYS_CONTROL: rdata_next = {27'h0000000, budget_data_unlock_reg,
					global_write_unlock_reg, 3'h0};
				default: rdata_next = spb_pkg::ZERO_WORD;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata <= spb_pkg::ZERO_WORD;
		end else if (rd) begin
			rdata <= rdata_next;
		end else begin
			rdata <= spb_pkg::ZERO_WORD;
		end
	end

	assign system_allocated_flag = sa_reg;
	assign reset_hold_latched = hold_reg;

	////////////////////////////////////////////////////////////////
	// Assertions
	property p_dv_locked;
		@(posedge clock) disable iff (rst)
		(wr && in_words && !budget_data_unlock_reg) |=>
			budget_data_word[$past(word_idx)] == $past(budget_data_word[word_idx]);
	endproperty
	a_dv_locked: assert property (p_dv_locked) else $error("locked budget word changed");

	property p_dv_write;
		@(posedge clock) disable iff (rst || hot_rst)
		(wr && in_words && budget_data_unlock_reg) ##1 (rd && addr == $past(addr))
			|=> rdata == $past(wdata, 2);
	endproperty
	a_dv_write: assert property (p_dv_write) else $error("budget word not stored");

	property p_sa_locked;
		@(posedge clock) disable iff (rst)
		(wr && addr == spb_pkg::OFF_PB_CAP && !global_write_unlock_reg) |=> $stable(sa_reg);
	endproperty
	a_sa_locked: assert property (p_sa_locked) else $error("flag changed while locked");

	property p_marker_hot;
		@(posedge clock) disable iff (rst)
		hot_rst |=> $stable(marker_reg);
	endproperty
	a_marker_hot: assert property (p_marker_hot) else $error("marker lost on hot reset");

	property p_sel_zero;
		@(posedge clock) disable iff (rst)
		(rd && addr == spb_pkg::OFF_PB_READBACK
			&& budget_word_selector_reg > spb_pkg::LAST_WORD_SEL)
			|=> rdata == 32'h0000_0000;
	endproperty
	a_sel_zero: assert property (p_sel_zero) else $error("readback not zero");

	property p_reserved;
		@(posedge clock) disable iff (rst)
		(rd && addr == spb_pkg::OFF_STATE_REPORT) |=>
			(rdata[4:3] == 2'h0 && rdata[8:7] == 2'h0 && rdata[19:10] == 10'h000
			&& rdata[27:23] == 5'h00);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits set");

	property p_hold_stable;
		@(posedge clock) disable iff (rst)
		!$past(rst) |-> $stable(hold_reg) && $stable(ds_clk_reg) && $stable(us_clk_reg);
	endproperty
	a_hold_stable: assert property (p_hold_stable) else $error("captured pin moved");

	property p_mode_read;
		@(posedge clock) disable iff (rst)
		(rd && addr == spb_pkg::OFF_STATE_REPORT) |=> rdata[2:0] == $past(mode_reg);
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("mode misreported");

	property p_lock_reset;
		@(posedge clock)
		hot_rst |=> lock_state_reg == spb_pkg::LOCK_RESET;
	endproperty
	a_lock_reset: assert property (p_lock_reset) else $error("lock state not reset");

	property p_sa_write;
		@(posedge clock) disable iff (rst)
		(wr && addr == spb_pkg::OFF_PB_CAP && global_write_unlock_reg) |=>
			sa_reg == $past(wdata[spb_pkg::SA_BIT]);
	endproperty
	a_sa_write: assert property (p_sa_write) else $error("flag write lost");

	property p_cap_reserved;
		@(posedge clock) disable iff (rst)
		(rd && addr == spb_pkg::OFF_PB_CAP) |=> rdata[31:1] == 31'h0;
	endproperty
	a_cap_reserved: assert property (p_cap_reserved) else $error("flag reserved bits set");

	property p_word_read;
		@(posedge clock) disable iff (rst)
		(rd && in_words) |=> rdata == $past(budget_data_word[word_idx]);
	endproperty
	a_word_read: assert property (p_word_read) else $error("budget word misread");

	property p_readback;
		@(posedge clock) disable iff (rst)
		(rd && addr == spb_pkg::OFF_PB_READBACK
			&& budget_word_selector_reg <= spb_pkg::LAST_WORD_SEL) |=>
			rdata == $past(budget_data_word[budget_word_selector_reg[3:0]]);
	endproperty
	a_readback: assert property (p_readback) else $error("selected word misread");

	property p_marker_locked;
		@(posedge clock) disable iff (rst)
		(wr && addr == spb_pkg::OFF_STATE_REPORT && !global_write_unlock_reg) |=>
			$stable(marker_reg);
	endproperty
	a_marker_locked: assert property (p_marker_locked) else $error("marker changed locked");

	property p_marker_write;
		@(posedge clock) disable iff (rst)
		(wr && addr == spb_pkg::OFF_STATE_REPORT && global_write_unlock_reg) |=>
			marker_reg == $past(wdata[spb_pkg::MARKER_LSB +: 4]);
	endproperty
	a_marker_write: assert property (p_marker_write) else $error("marker write lost");

	property p_marker_fund;
		@(posedge clock)
		rst |=> marker_reg == spb_pkg::MARKER_RESET;
	endproperty
	a_marker_fund: assert property (p_marker_fund) else $error("marker not cleared");

	property p_unlock_reset;
		@(posedge clock)
		(rst || hot_rst) |=> global_write_unlock_reg;
	endproperty
	a_unlock_reset: assert property (p_unlock_reset) else $error("unlock not set by reset");

	property p_dvul_locked;
		@(posedge clock) disable iff (rst)
		(wr && addr == spb_pkg::OFF_SYS_CONTROL && !global_write_unlock_reg) |=>
			$stable(budget_data_unlock_reg);
	endproperty
	a_dvul_locked: assert property (p_dvul_locked) else $error("word unlock changed");

	property p_ctrl_read;
		@(posedge clock) disable iff (rst)
		(rd && addr == spb_pkg::OFF_SYS_CONTROL) |=>
			rdata[spb_pkg::UNLOCK_BIT] == $past(global_write_unlock_reg)
			&& rdata[spb_pkg::DV_UNLOCK_BIT] == $past(budget_data_unlock_reg);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("unlock bits misread");

	property p_pins_capture;
		@(posedge clock)
		rst |=> mode_reg == $past(operating_mode_field)
			&& ds_clk_reg == $past(downstream_common_clock_pin)
			&& us_clk_reg == $past(upstream_common_clock_pin)
			&& hold_reg == $past(reset_hold_pin);
	endproperty
	a_pins_capture: assert property (p_pins_capture) else $error("pins not captured");

	property p_pins_read;
		@(posedge clock) disable iff (rst)
		(rd && addr == spb_pkg::OFF_STATE_REPORT) |=>
			rdata[spb_pkg::DS_CLK_BIT] == $past(ds_clk_reg)
			&& rdata[spb_pkg::US_CLK_BIT] == $past(us_clk_reg)
			&& rdata[spb_pkg::HOLD_BIT] == $past(hold_reg);
	endproperty
	a_pins_read: assert property (p_pins_read) else $error("captured pins misread");

	property p_lock_read;
		@(posedge clock) disable iff (rst)
		(rd && addr == spb_pkg::OFF_STATE_REPORT) |=>
			rdata[spb_pkg::LOCK_LSB +: 3] == $past(lock_state_reg)
			&& rdata[spb_pkg::MARKER_LSB +: 4] == $past(marker_reg);
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("lock or marker misread");

	property p_lock_follow;
		@(posedge clock) disable iff (rst || hot_rst)
		1'b1 |=> lock_state_reg == $past(lock_state_in);
	endproperty
	a_lock_follow: assert property (p_lock_follow) else $error("lock state not tracked");

	property p_sel_read;
		@(posedge clock) disable iff (rst)
		(rd && addr == spb_pkg::OFF_PB_SELECT) |=> rdata[31:8] == 24'h000000;
	endproperty
	a_sel_read: assert property (p_sel_read) else $error("selector reserved bits set");

	c_dv_write: cover property (@(posedge clock) wr && in_words && budget_data_unlock_reg);
	c_marker: cover property (@(posedge clock) wr && addr == spb_pkg::OFF_STATE_REPORT);
	c_sel_hi: cover property (@(posedge clock) rd && budget_word_selector_reg > 8'h09);
	c_hot_keep: cover property (@(posedge clock) hot_rst && marker_reg != 4'h0);
	c_dv_refused: cover property (@(posedge clock) wr && in_words && !budget_data_unlock_reg);
endmodule : spb_regs

// [switch_power_budget_status_regs_tb.sv]
// Self-checking bench for the power budget and status bank
`timescale 1ns/1ps
module switch_power_budget_status_regs_tb;
	logic clock, rst, hot_rst, ds, us, hold, wr, rd, sa_flag, hold_l;
	logic rd_seen = 1'b0;
	logic [2:0] mode, lock;
	logic [11:0] addr;
	logic [31:0] wdata, rdata;
	logic [9:0] pin_exp = 10'h221;
	logic [31:0] w [10];
	logic [31:0] exp_q [$];
	string nm_q [$];
	integer seed = 32'hfa54cf7a;
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	spb_host host (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
	spb_regs dut (.clock(clock), .rst(rst), .hot_rst(hot_rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .operating_mode_field(mode),
		.downstream_common_clock_pin(ds), .upstream_common_clock_pin(us),
		.reset_hold_pin(hold), .lock_state_in(lock), .system_allocated_flag(sa_flag),
		.reset_hold_latched(hold_l));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		if (errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test
	// Read with expected value noted
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
		exp_q.push_back(e);
		nm_q.push_back(nm);
		host.acc(1'b0, a, 32'h0000_0000);
	endtask : rdc
	// Status read; low ten bits hold the captured pins
	task automatic stat(input logic [3:0] mk, input string nm);
		rdc(spb_pkg::OFF_STATE_REPORT, {mk, 5'h00, lock, 10'h000, pin_exp}, nm);
	endtask : stat
	// Answer one cycle after each read
	always @(posedge clock) begin
		cyc <= cyc + 1;
		rd_seen <= rd;
		if (rd_seen) begin
			check(nm_q.pop_front(), rdata, exp_q.pop_front());
		end
		if (cyc == 2000) begin
			errors++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		hot_rst = 1'b0;
		{mode, ds, us, hold} = 6'h0d;
		lock = 3'h3;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		{mode, ds, us, hold} <= 6'($random(seed));
		host.idle();
		stat(4'h0, "status");
		check("hold out", 32'(hold_l), 32'h1);
		// Initial load while unlocked
		host.acc(1'b1, spb_pkg::OFF_SYS_CONTROL, 32'h18);
		host.acc(1'b1, spb_pkg::OFF_PB_CAP, 32'hffff_ffff);
		host.acc(1'b1, spb_pkg::OFF_STATE_REPORT, 32'hffff_ffff);
		for (int i = 0; i < 10; i++) begin
			w[i] = $random(seed);
			host.acc(1'b1, spb_pkg::OFF_PB_WORDS + 12'(4 * i), w[i]);
			rdc(spb_pkg::OFF_PB_WORDS + 12'(4 * i), w[i], "word");
		end
		rdc(spb_pkg::OFF_PB_CAP, 32'h1, "flag");
		stat(4'hf, "marker");
		for (int i = 0; i < 12; i++) begin
			host.acc(1'b1, spb_pkg::OFF_PB_SELECT, i == 11 ? 32'hff : 32'(i));
			rdc(spb_pkg::OFF_PB_READBACK, i < 10 ? w[i % 10] : 32'h0, "readback");
		end
		rdc(spb_pkg::OFF_PB_SELECT, 32'hff, "selector");
		check("flag out", 32'(sa_flag), 32'h1);
		// Lock everything, then try writes
		host.acc(1'b1, spb_pkg::OFF_SYS_CONTROL, 32'h0);
		host.acc(1'b1, spb_pkg::OFF_PB_CAP, 32'h0);
		host.acc(1'b1, spb_pkg::OFF_STATE_REPORT, 32'h0);
		host.acc(1'b1, spb_pkg::OFF_PB_WORDS + 12'h024, 32'h0);
		host.acc(1'b1, spb_pkg::OFF_SYS_CONTROL, 32'h10);
		rdc(spb_pkg::OFF_PB_CAP, 32'h1, "flag locked");
		rdc(spb_pkg::OFF_PB_WORDS + 12'h024, w[9], "word locked");
		rdc(spb_pkg::OFF_SYS_CONTROL, 32'h0, "control locked");
		stat(4'hf, "marker locked");
		// Hot reset keeps sticky state
		hot_rst <= 1'b1;
		host.idle();
		hot_rst <= 1'b0;
		host.acc(1'b1, spb_pkg::OFF_PB_WORDS, 32'h0);
		rdc(spb_pkg::OFF_PB_WORDS, w[0], "word hot");
		stat(4'hf, "marker hot");
		for (int i = 0; i < 4; i++) begin
			lock <= 3'(i == 0 ? 0 : i + 1);
			host.idle();
			stat(4'hf, "lock state");
		end
		host.acc(1'b1, spb_pkg::OFF_STATE_REPORT, 32'h5000_0000);
		stat(4'h5, "marker write");
		rdc(12'h3fc, 32'h0, "unmapped");
		rdc(12'h340, 32'h0, "word alias");
		check("flag hot", 32'(sa_flag), 32'h1);
		// Second fundamental reset clears flag and marker, recaptures pins
		{mode, ds, us, hold} <= 6'h02;
		rst <= 1'b1;
		host.idle();
		host.idle();
		rst <= 1'b0;
		{mode, ds, us, hold} <= 6'($random(seed));
		pin_exp = 10'h040;
		host.idle();
		stat(4'h0, "marker cleared");
		rdc(spb_pkg::OFF_PB_CAP, 32'h0, "flag cleared");
		rdc(spb_pkg::OFF_SYS_CONTROL, 32'h8, "control reset");
		check("hold cleared", 32'(hold_l), 32'h0);
		check("flag out cleared", 32'(sa_flag), 32'h0);
		host.idle();
		host.idle();
		stop_test();
	end
endmodule : switch_power_budget_status_regs_tb
